// *** display_port_pkg.sv ***
/*
 display_port_pkg: constants and types for the 8-bit parallel display port block.
 assumes a single 25 MHz system clock and an active-high asynchronous reset.
*/
`default_nettype none
package display_port_pkg;
    localparam int unsigned CLK_HZ           = 25_000_000;
    localparam int unsigned CLK_PERIOD_NS    = 40;
    localparam int unsigned TIMER_W          = 20;
    localparam int unsigned SETUP_NS         = 40;
    localparam int unsigned STROBE_NS        = 80;
    localparam int unsigned HOLD_NS          = 40;
    localparam int unsigned RESET_PULSE_NS   = 10_000;
    localparam int unsigned RESET_RECOVER_US = 5_000;
    localparam int unsigned SPI_HALF_NS      = 80;
    // least times round up to whole cycles
    localparam int unsigned SETUP_CYCLES  = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned STROBE_CYCLES = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned HOLD_CYCLES   = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RESET_PULSE_CYCLES =
        (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RESET_RECOVER_DEF = RESET_RECOVER_US * (CLK_HZ / 1_000_000);
    localparam int unsigned SPI_HALF_CYCLES =
        (SPI_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned DATA_W     = 8;
    localparam int unsigned CMD_W      = 10;
    localparam int unsigned FIFO_DEPTH = 16;
    localparam int unsigned CMD_READ_BIT = 9;
    localparam int unsigned CMD_RS_BIT   = 8;
    localparam logic [7:0] BUS_RELEASED = 8'hff;
    localparam logic [7:0] BUS_DRIVEN   = 8'h00;
    localparam logic [7:0] PWM_RESET    = 8'h00;

    typedef enum logic [1:0] {
        PARALLEL_NO_TOUCH_VARIANT,
        PARALLEL_RESISTIVE_VARIANT,
        PARALLEL_CAPACITIVE_VARIANT
    } touch_variant_e;
endpackage
`default_nettype wire

// *** cmd_fifo.sv ***
/*
 cmd_fifo: flip-flop FIFO with valid/ready on both sides.
 assumes one clock and an active-high asynchronous reset.
*/
`timescale 1ns/1ns
`default_nettype none
module cmd_fifo #(
    parameter int unsigned WIDTH = 10,
    parameter int unsigned DEPTH = 16
) (
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rst,
    // fill side
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // drain side
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int unsigned PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wrPtr;
    logic [PW-1:0]    rdPtr;
    logic [PW:0]      count;
    logic             doWrite;
    logic             doRead;

    assign inReady  = (count != (PW+1)'(DEPTH));
    assign outValid = (count != '0);
    assign outData  = mem[rdPtr];
    assign doWrite  = inValid && inReady;
    assign doRead   = outValid && outReady;

    always_ff @(posedge sys_clk)
    begin
        if (doWrite)
        begin
            mem[wrPtr] <= inData;
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end
        else
        begin
            if (doWrite)
            begin
                wrPtr <= (wrPtr == PW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
            end
            if (doRead)
            begin
                rdPtr <= (rdPtr == PW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
            end
            if (doWrite && !doRead)
            begin
                count <= count + 1'b1;
            end
            else if (doRead && !doWrite)
            begin
                count <= count - 1'b1;
            end
        end
    end
endmodule // cmd_fifo
`default_nettype wire

// *** mcu8_display_port.sv ***
/*
 mcu8_display_port: 8-bit parallel display bus engine with command FIFO, display reset
 sequencing, backlight and audio PWM, touch pin muxing, SD/flash SPI and serial pins.
 assumes all inputs synchronous to sys_clk; the two-way pins are resolved outside.
*/
`timescale 1ns/1ns
`default_nettype none
module mcu8_display_port
    import display_port_pkg::*;
#(
    parameter int unsigned RESET_RECOVER_CYCLES = display_port_pkg::RESET_RECOVER_DEF
) (
    // clock and reset
    input  wire logic                            sys_clk,
    input  wire logic                            rst,
    // command stream: {read, regSelect, byte}
    input  wire logic                            cmdValid,
    output logic                                 cmdReady,
    input  wire logic [display_port_pkg::CMD_W-1:0] cmdData,
    input  wire logic                            dispResetReq,
    output logic                                 dispReady,
    // read answers
    output logic                                 rdValid,
    output logic      [7:0]                      rdData,
    // display bus
    input  wire logic [7:0]                      dispBusIn,
    output logic      [7:0]                      dispBusOut,
    output logic      [7:0]                      dispBusOeN,
    output logic                                 displayReadStrobeN,
    output logic                                 displayWriteStrobeN,
    output logic                                 displayRegSelect,
    output logic                                 displayChipSelectN,
    output logic                                 displayResetN,
    // backlight and audio
    input  wire logic [7:0]                      blLevel,
    input  wire logic [7:0]                      audioSample,
    input  wire logic                            ampOn,
    output logic                                 backlight,
    output logic                                 audioPwm,
    output logic                                 ampEnable,
    // touch pins: 0 left/scl, 1 up/reset, 2 down/int, 3 right/sda
    input  wire display_port_pkg::touch_variant_e touchVariant,
    input  wire logic                            thirdI2cOn,
    input  wire logic [3:0]                      touchPinIn,
    output logic      [3:0]                      touchPinOut,
    output logic      [3:0]                      touchPinOeN,
    input  wire logic [3:0]                      touchDrive,
    input  wire logic [3:0]                      touchDriveOeN,
    output logic      [3:0]                      touchSense,
    input  wire logic                            i2cSclLow,
    input  wire logic                            i2cSdaLow,
    input  wire logic                            touchCtrlResetN,
    output logic                                 i2cSclIn,
    output logic                                 i2cSdaIn,
    output logic                                 touchInt,
    // SD / flash SPI
    input  wire logic                            memSelect,
    input  wire logic                            spiStart,
    input  wire logic [7:0]                      spiTx,
    output logic                                 spiBusy,
    output logic                                 spiDone,
    output logic      [7:0]                      spiRx,
    output logic                                 memCsN,
    output logic                                 memSck,
    output logic                                 memMosi,
    input  wire logic                            memMiso,
    // serial ports
    input  wire logic                            uart0Tx,
    output logic                                 uart0Rx,
    input  wire logic                            uart1Tx,
    output logic                                 uart1Rx,
    input  wire logic                            uart1On,
    output logic                                 primarySerialOut,
    input  wire logic                            primarySerialIn,
    input  wire logic [1:0]                      serialGpioIn,
    output logic      [1:0]                      serialGpioOut,
    output logic      [1:0]                      serialGpioOeN
);
    typedef enum logic [2:0] {
        ST_RESET_LOW, ST_RESET_WAIT, ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD
    } bus_state_e;

    function automatic logic inTransfer(input bus_state_e s);
        return (s == ST_SETUP) || (s == ST_STROBE) || (s == ST_HOLD);
    endfunction

    bus_state_e             state;
    bus_state_e             next_state;
    logic [TIMER_W-1:0]     timer;
    logic [TIMER_W-1:0]     next_timer;
    logic                   fifoValid;
    logic                   fifoReady;
    logic [CMD_W-1:0]       fifoData;
    logic                   curRead;
    logic                   next_read;
    logic [7:0]             pwmCount;

    cmd_fifo #(.WIDTH(CMD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .inValid  (cmdValid),
        .inReady  (cmdReady),
        .inData   (cmdData),
        .outValid (fifoValid),
        .outReady (fifoReady),
        .outData  (fifoData)
    );

    // a pending display reset request wins over queued transfers
    assign fifoReady = (state == ST_IDLE) && !dispResetReq;
    assign dispReady = (state == ST_IDLE);
    assign next_read = fifoReady ? fifoData[CMD_READ_BIT] : curRead;

    always_comb
    begin
        next_state = state;
        next_timer = timer + 1'b1;
        case (state)
            ST_RESET_LOW:
                if (timer == TIMER_W'(RESET_PULSE_CYCLES - 1))
                begin
                    next_state = ST_RESET_WAIT;
                end
            ST_RESET_WAIT:
                if (timer == TIMER_W'(RESET_RECOVER_CYCLES - 1))
                begin
                    next_state = ST_IDLE;
                end
            ST_IDLE:
                if (dispResetReq)
                begin
                    next_state = ST_RESET_LOW;
                end
                else if (fifoValid)
                begin
                    next_state = ST_SETUP;
                end
            ST_SETUP:
                if (timer == TIMER_W'(SETUP_CYCLES - 1))
                begin
                    next_state = ST_STROBE;
                end
            ST_STROBE:
                if (timer == TIMER_W'(STROBE_CYCLES - 1))
                begin
                    next_state = ST_HOLD;
                end
            ST_HOLD:
                if (timer == TIMER_W'(HOLD_CYCLES - 1))
                begin
                    next_state = ST_IDLE;
                end
            default:
                next_state = ST_RESET_LOW;
        endcase
        if (next_state != state)
        begin
            next_timer = '0;
        end
    end

    // the display is pulsed into reset whenever the device leaves its own reset
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            state <= ST_RESET_LOW;
            timer <= '0;
        end
        else
        begin
            state <= next_state;
            timer <= next_timer;
        end
    end

    // address and data are latched once per transfer and held through hold time
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            curRead          <= 1'b0;
            displayRegSelect <= 1'b0;
            dispBusOut       <= 8'h00;
        end
        else if (fifoReady && fifoValid)
        begin
            curRead          <= fifoData[CMD_READ_BIT];
            displayRegSelect <= fifoData[CMD_RS_BIT];
            dispBusOut       <= fifoData[7:0];
        end
    end

    // pins are registered from the next state so strobes never glitch
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            displayReadStrobeN  <= 1'b1;
            displayWriteStrobeN <= 1'b1;
            displayChipSelectN  <= 1'b1;
            dispBusOeN          <= BUS_RELEASED;
            displayResetN       <= 1'b0;
        end
        else
        begin
            displayReadStrobeN  <= !(next_state == ST_STROBE && next_read);
            displayWriteStrobeN <= !(next_state == ST_STROBE && !next_read);
            displayChipSelectN  <= !inTransfer(next_state);
            dispBusOeN <= (inTransfer(next_state) && !next_read) ? BUS_DRIVEN
                                                                : BUS_RELEASED;
            displayResetN <= (next_state != ST_RESET_LOW);
        end
    end

    // sample the display byte on the last strobe cycle while it still drives
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            rdData  <= 8'h00;
            rdValid <= 1'b0;
        end
        else
        begin
            if (state == ST_STROBE && curRead && next_state == ST_HOLD)
            begin
                rdData <= dispBusIn;
            end
            rdValid <= (state == ST_HOLD) && curRead && (next_state == ST_IDLE);
        end
    end

    // one shared 8-bit ramp; level 0 keeps the converter off, ff never reaches 100%
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            pwmCount  <= PWM_RESET;
            backlight <= 1'b0;
            audioPwm  <= 1'b0;
            ampEnable <= 1'b0;
        end
        else
        begin
            pwmCount  <= pwmCount + 1'b1;
            backlight <= (pwmCount < blLevel);
            audioPwm  <= (pwmCount < audioSample);
            ampEnable <= ampOn;
        end
    end

    // touch pin roles per variant; open-drain lines only ever pull low
    always_comb
    begin
        touchPinOut = touchDrive;
        touchPinOeN = touchDriveOeN;
        touchSense  = touchPinIn;
        i2cSclIn    = 1'b1;
        i2cSdaIn    = 1'b1;
        touchInt    = 1'b1;
        case (touchVariant)
            PARALLEL_RESISTIVE_VARIANT:
            begin
                touchPinOut = touchDrive;
                touchPinOeN = touchDriveOeN;
            end
            PARALLEL_CAPACITIVE_VARIANT:
            begin
                touchPinOut = {1'b0, 1'b1, touchCtrlResetN, 1'b0};
                touchPinOeN = {!i2cSdaLow, 1'b1, 1'b0, !i2cSclLow};
                i2cSclIn    = touchPinIn[0];
                i2cSdaIn    = touchPinIn[3];
                touchInt    = touchPinIn[2];
            end
            default:
            begin
                if (thirdI2cOn)
                begin
                    touchPinOut[0] = 1'b0;
                    touchPinOut[3] = 1'b0;
                    touchPinOeN[0] = !i2cSclLow;
                    touchPinOeN[3] = !i2cSdaLow;
                    i2cSclIn       = touchPinIn[0];
                    i2cSdaIn       = touchPinIn[3];
                end
            end
        endcase
    end

    // serial: pair 0 dedicated, pair 1 borrows two general purpose pins
    assign primarySerialOut = uart0Tx;
    assign uart0Rx          = primarySerialIn;
    assign serialGpioOut    = {1'b1, uart1Tx};
    assign serialGpioOeN    = {1'b1, !uart1On};
    assign uart1Rx          = uart1On ? serialGpioIn[1] : 1'b1;

    // SPI mode 0 byte shifter for the memory card or flash
    logic [7:0]             spiShift;
    logic [3:0]             spiEdges;
    logic [TIMER_W-1:0]     spiDiv;

    assign memCsN = !memSelect;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            spiBusy  <= 1'b0;
            spiDone  <= 1'b0;
            spiShift <= 8'h00;
            spiRx    <= 8'h00;
            spiEdges <= 4'h0;
            spiDiv   <= '0;
            memSck   <= 1'b0;
            memMosi  <= 1'b0;
        end
        else
        begin
            spiDone <= 1'b0;
            if (!spiBusy)
            begin
                memSck <= 1'b0;
                if (spiStart)
                begin
                    spiBusy  <= 1'b1;
                    spiShift <= {spiTx[6:0], 1'b0};
                    memMosi  <= spiTx[7];
                    spiEdges <= 4'h0;
                    spiDiv   <= '0;
                end
            end
            else if (spiDiv == TIMER_W'(SPI_HALF_CYCLES - 1))
            begin
                spiDiv   <= '0;
                memSck   <= !memSck;
                spiEdges <= spiEdges + 1'b1;
                if (!memSck)
                begin
                    spiRx <= {spiRx[6:0], memMiso};
                end
                else
                begin
                    memMosi  <= spiShift[7];
                    spiShift <= {spiShift[6:0], 1'b0};
                end
                if (spiEdges == 4'hf)
                begin
                    spiBusy <= 1'b0;
                    spiDone <= 1'b1;
                end
            end
            else
            begin
                spiDiv <= spiDiv + 1'b1;
            end
        end
    end

    a_write_width: assert property (@(posedge sys_clk) disable iff (rst)
        $fell(displayWriteStrobeN) |-> ##1 !displayWriteStrobeN ##1 displayWriteStrobeN)
        else $error("write strobe not two cycles low");
    a_read_width: assert property (@(posedge sys_clk) disable iff (rst)
        $fell(displayReadStrobeN) |-> ##1 !displayReadStrobeN ##1 displayReadStrobeN)
        else $error("read strobe not two cycles low");
    a_write_drives: assert property (@(posedge sys_clk) disable iff (rst)
        !displayWriteStrobeN |-> dispBusOeN == 8'h00)
        else $error("bus released during write strobe");
    a_read_releases: assert property (@(posedge sys_clk) disable iff (rst)
        !displayReadStrobeN |-> dispBusOeN == 8'hff && displayWriteStrobeN)
        else $error("bus driven during read strobe");
    a_setup_hold: assert property (@(posedge sys_clk) disable iff (rst)
        $fell(displayWriteStrobeN) |-> $stable(displayRegSelect) && !displayChipSelectN
        ##2 $stable(dispBusOut) && !displayChipSelectN && dispBusOeN == 8'h00)
        else $error("select or data moved around write strobe");
    a_reset_pulse: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(displayResetN) |-> $past(displayResetN, 200) == 1'b0
        && displayWriteStrobeN && displayReadStrobeN)
        else $error("display reset pulse too short");
    a_read_answer: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(displayReadStrobeN) |-> ##1 rdValid && rdData == $past(dispBusIn, 2))
        else $error("read byte not returned");
    a_backlight_off: assert property (@(posedge sys_clk) disable iff (rst)
        $past(blLevel) == 8'h00 |-> !backlight)
        else $error("backlight on at zero level");
    a_cap_pins: assert property (@(posedge sys_clk) disable iff (rst)
        touchVariant == PARALLEL_CAPACITIVE_VARIANT |->
        touchPinOeN[2] && !touchPinOeN[1] && touchPinOut[1] == touchCtrlResetN)
        else $error("capacitive pin roles wrong");
    a_spi_length: assert property (@(posedge sys_clk) disable iff (rst)
        spiStart && !spiBusy |-> ##33 spiDone)
        else $error("spi byte not 16 half periods");
endmodule // mcu8_display_port
`default_nettype wire

// *** display_model.sv ***
/*
 display_model: display controller on the far side of the 8-bit bus.
 assumes the bench resolves the shared data pins from both enables.
*/
`timescale 1ns/1ns
`default_nettype none
module display_model (
    // strobes from the device
    input  wire logic       readN,
    input  wire logic       writeN,
    // resolved data pins
    input  wire logic [7:0] busIn,
    // answer path, enable active low
    output logic      [7:0] busOut,
    output logic            busOeN
);
    logic [7:0] stored = 8'h00;
    // taken on the rising write edge, while the device still holds the byte
    always @(posedge writeN) stored <= busIn;
    // drives only while read strobe is low; answers the inverted last byte
    assign busOeN = readN;
    assign busOut = ~stored;
endmodule // display_model
`default_nettype wire

// *** tb.sv ***
/*
 tb: self-checking bench for mcu8_display_port with a display model.
 assumes a 25 MHz clock and a shortened display recovery count.
*/
`timescale 1ns/1ns
`default_nettype none
module tb;
    import display_port_pkg::*;
    logic       sys_clk, rst, cmdValid, dispResetReq, ampOn, spiStart, mOeN;
    logic       cmdReady, dispReady, rdValid, displayReadStrobeN, displayWriteStrobeN;
    logic       displayRegSelect, displayResetN, backlight, ampEnable, spiDone, memMosi;
    logic       primarySerialOut, audioPwm, displayChipSelectN, thirdI2c;
    touch_variant_e variant;
    logic       wPrev = 1'b1;
    logic [9:0] cmdData;
    logic [7:0] blLevel, dispBusIn, mOut, rdData, dispBusOut, dispBusOeN, spiRx;
    logic [7:0] tick = 8'h00;
    logic [3:0] touchPinOut, touchPinOeN;
    logic [1:0] serialGpioOut;
    logic [9:0] got[$];
    int         n, checked, failures, audioHigh;
    // reads are {1, select, byte} and are logged as {10, byte}; writes are {0, select, byte}
    logic [9:0] rowCmd[8] = '{10'h02c, 10'h181, 10'h300, 10'h100, 10'h200, 10'h1ff, 10'h300, 10'h0a5};
    logic [9:0] rowExp[8] = '{10'h02c, 10'h181, 10'h27e, 10'h100, 10'h2ff, 10'h1ff, 10'h200, 10'h0a5};

    // nobody driving leaves a pattern that moves every cycle
    assign dispBusIn = (dispBusOeN == 8'h00) ? dispBusOut : (!mOeN ? mOut : tick);

    mcu8_display_port #(.RESET_RECOVER_CYCLES(20)) DUT (
        .sys_clk, .rst, .cmdValid, .cmdReady, .cmdData, .dispResetReq, .dispReady, .rdValid,
        .rdData, .dispBusIn, .dispBusOut, .dispBusOeN, .displayReadStrobeN,
        .displayWriteStrobeN, .displayRegSelect, .displayChipSelectN, .displayResetN,
        .blLevel, .audioSample(8'hff), .ampOn, .backlight, .audioPwm, .ampEnable,
        .touchVariant(variant), .thirdI2cOn(thirdI2c), .touchPinIn(touchPinOut),
        .touchPinOut, .touchPinOeN, .touchDrive(tick[3:0]), .touchDriveOeN(tick[7:4]),
        .touchSense(), .i2cSclLow(tick[0]), .i2cSdaLow(tick[1]), .touchCtrlResetN(tick[2]),
        .i2cSclIn(), .i2cSdaIn(), .touchInt(), .memSelect(tick[3]), .spiStart, .spiTx(8'ha5),
        .spiBusy(), .spiDone, .spiRx, .memCsN(), .memSck(), .memMosi, .memMiso(memMosi),
        .uart0Tx(tick[4]), .uart0Rx(), .uart1Tx(tick[5]), .uart1Rx(), .uart1On(tick[6]),
        .primarySerialOut, .primarySerialIn(primarySerialOut), .serialGpioIn(serialGpioOut),
        .serialGpioOut, .serialGpioOeN()
    );

    display_model display (
        .readN(displayReadStrobeN), .writeN(displayWriteStrobeN), .busIn(dispBusIn),
        .busOut(mOut), .busOeN(mOeN)
    );

    task check(input logic [9:0] g, input logic [9:0] e);
        checked++;
        if (g !== e)
        begin
            failures++;
            $display("mismatch at %0t got %h exp %h", $time, g, e);
        end
    endtask

    task step;
        @(posedge sys_clk);
        #2;
    endtask

    task stop_test;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) tick <= tick + 8'h01;

    // writes are logged after the strobe, in the hold cycle; reads one cycle later, while rdValid is high
    always @(negedge sys_clk)
    begin
        if (!rst && !wPrev && displayWriteStrobeN) got.push_back({1'b0, displayRegSelect, dispBusOut});
        if (rdValid) got.push_back({2'b10, rdData});
        if (!displayWriteStrobeN) check(dispBusOeN, 8'h00);
        if (!displayReadStrobeN) check(dispBusOeN, 8'hff);
        if (!displayWriteStrobeN || !displayReadStrobeN) check(displayChipSelectN, 1'b0);
        wPrev = displayWriteStrobeN;
    end

    initial
    begin
        #400000;
        failures++;
        stop_test;
    end

    initial
    begin
        rst = 1'b1; cmdValid = 1'b0; cmdData = 10'h000; dispResetReq = 1'b0;
        ampOn = 1'b0; spiStart = 1'b0; blLevel = 8'h40;
        variant = PARALLEL_RESISTIVE_VARIANT; thirdI2c = 1'b0;
        repeat (12) @(posedge sys_clk);
        #2 rst = 1'b0;
        // queued while the display reset is still low: sixteen fill the buffer, a seventeenth is refused
        for (int i = 0; i < 17; i++)
        begin
            cmdValid = 1'b1;
            cmdData = (i < 16) ? rowCmd[i % 8] : 10'h0ee;
            step;
        end
        check(cmdReady, 1'b0);
        check(displayResetN, 1'b0);
        cmdValid = 1'b0;
        n = 0;
        while (got.size() < 16 && n < 3000) begin step; n++; end
        repeat (20) step;
        check(10'(got.size()), 10'd16);
        for (int i = 0; i < 16; i++) check(got[i], rowExp[i % 8]);
        dispResetReq = 1'b1;
        n = 0;
        while (displayResetN && n < 50) begin step; n++; end
        dispResetReq = 1'b0;
        n = 0;
        while (!displayResetN && n < 400) begin step; n++; end
        check(10'(n), 10'(RESET_PULSE_CYCLES));
        n = 0;
        repeat (256) begin step; n = n + backlight; audioHigh = audioHigh + audioPwm; end
        check(10'(n), 10'd64);
        check(10'(audioHigh), 10'd255);
        // level zero must keep the converter off for a whole period
        blLevel = 8'h00;
        n = 0;
        repeat (256) begin step; n = n + backlight; end
        check(10'(n), 10'd0);
        check(ampEnable, 1'b0);
        ampOn = 1'b1;
        step;
        step;
        check(ampEnable, 1'b1);
        check(primarySerialOut, tick[4]);
        check(touchPinOut, tick[3:0]);
        variant = PARALLEL_CAPACITIVE_VARIANT;
        step;
        check(touchPinOut[1], tick[2]);
        check(touchPinOeN, {~tick[1], 2'b10, ~tick[0]});
        variant = PARALLEL_NO_TOUCH_VARIANT;
        thirdI2c = 1'b1;
        step;
        check(touchPinOeN, {~tick[1], tick[6:5], ~tick[0]});
        spiStart = 1'b1;
        step;
        spiStart = 1'b0;
        n = 0;
        while (!spiDone && n < 100) begin step; n++; end
        check(10'(n), 10'd32);
        check(spiRx, 8'ha5);
        stop_test;
    end
endmodule // tb
`default_nettype wire
